// *** pdc_pkg.sv ***
// Package of constants for the power-down control decode block
`default_nettype none
package pdc_pkg;
    // Register offsets (byte addresses)
    localparam logic [31:0] PDC_CFR_ONE_OFFSET = 32'h0000_0000;
    localparam logic [31:0] PDC_STATUS_OFFSET  = 32'h0000_0004;
    // Field positions in control_function_reg_one
    localparam int PDC_DIG_PD_BIT   = 7;
    localparam int PDC_PLL_PD_BIT   = 6;
    localparam int PDC_DAC_PD_BIT   = 5;
    localparam int PDC_CLK_PD_BIT   = 4;
    localparam int PDC_FULL_PD_BIT  = 3;
    // Writable bits of control_function_reg_one
    localparam logic [31:0] PDC_CFR_ONE_MASK  = 32'h0000_00F8;
    localparam logic [31:0] PDC_CFR_ONE_RESET = 32'h0000_0000;
    // Status field positions
    localparam int PDC_ST_DIG_BIT   = 0;
    localparam int PDC_ST_PLL_BIT   = 1;
    localparam int PDC_ST_DAC_BIT   = 2;
    localparam int PDC_ST_CLK_BIT   = 3;
    localparam int PDC_ST_PIN_BIT   = 4;
    localparam int PDC_ST_MODE_LSB  = 5;
    // AHB constants
    localparam logic [1:0] PDC_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] PDC_HTRANS_SEQ    = 2'h3;
    // Power mode encoding
    typedef enum logic [1:0] {
        PDC_MODE_SOFTWARE = 2'b00,
        PDC_MODE_FAST     = 2'b01,
        PDC_MODE_FULL     = 2'b10
    } pdc_mode_type;
endpackage
`default_nettype wire

// *** pdc_decode.sv ***
// Combinational power-down decode from pin and control bits
`default_nettype none
module pdc_decode
    import pdc_pkg::*;
(
    input  wire logic         ext_pd_i,
    input  wire logic [31:0]  cfr_one_i,
    output pdc_pkg::pdc_mode_type mode_o,
    output logic              dig_pd_o,
    output logic              pll_pd_o,
    output logic              dac_pd_o,
    output logic              clk_pd_o
);
    always_comb begin
        // PLL bit stays effective regardless of the pin
        pll_pd_o = cfr_one_i[PDC_PLL_PD_BIT];
        if (!ext_pd_i) begin
            mode_o   = PDC_MODE_SOFTWARE;
            dig_pd_o = cfr_one_i[PDC_DIG_PD_BIT];
            dac_pd_o = cfr_one_i[PDC_DAC_PD_BIT];
            clk_pd_o = cfr_one_i[PDC_CLK_PD_BIT];
        end else if (!cfr_one_i[PDC_FULL_PD_BIT]) begin
            // DAC and clock input stay up for quick wake; PLL follows its bit
            mode_o   = PDC_MODE_FAST;
            dig_pd_o = 1'b1;
            dac_pd_o = 1'b0;
            clk_pd_o = 1'b0;
        end else begin
            mode_o   = PDC_MODE_FULL;
            dig_pd_o = 1'b1;
            dac_pd_o = 1'b1;
            clk_pd_o = 1'b1;
        end
    end
endmodule // pdc_decode
`default_nettype wire

// *** pdc_top.sv ***
// Power-down control top: AHB-Lite registers, pin synchroniser, decode
//
// Functional notes
// - Four control bits 7:4 power down digital, PLL, DAC, clock input.
// - Pin high: only the PLL bit keeps effect, others ignored.
// - Pin low: digital, DAC, clock follow bits 7, 5, 4.
// - Pin high, bit 3 clear: digital down, DAC and clock up.
// - Pin high, bit 3 set: digital, DAC, clock all down.
// - Every power-down output is high for low power, low for active.
// - Fast recovery keeps DAC and clock input powered; PLL follows bit 6.
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`default_nettype none
module pdc_top
    import pdc_pkg::*;
(
    input  wire logic        CORE_CLK_I,
    input  wire logic        RSTN_I,
    input  wire logic        EXTERNAL_POWER_DOWN_PIN_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic [31:0]      HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    output logic             DIGITAL_PD_O,
    output logic             PLL_PD_O,
    output logic             DAC_PD_O,
    output logic             CLOCK_IN_PD_O
);
    import pdc_pkg::*;

    logic         pin_meta_reg;
    logic         pin_sync_reg;
    logic [31:0]  cfr_one_reg;
    logic         wr_pend_reg;
    logic         rd_pend_reg;
    logic [31:0]  addr_reg;
    logic [31:0]  rdata_next;
    pdc_mode_type mode;
    logic         dig_pd;
    logic         pll_pd;
    logic         dac_pd;
    logic         clk_pd;
    logic         bus_go;

    // Pin is asynchronous to the core clock
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= EXTERNAL_POWER_DOWN_PIN_I;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign bus_go = HSEL_I && HREADY_I &&
                    (HTRANS_I == PDC_HTRANS_NONSEQ || HTRANS_I == PDC_HTRANS_SEQ);

    // Address phase capture; data phase follows one cycle later
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= bus_go && HWRITE_I;
            rd_pend_reg <= bus_go && !HWRITE_I;
            if (bus_go) begin
                addr_reg <= HADDR_I;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            cfr_one_reg <= PDC_CFR_ONE_RESET;
        end else if (wr_pend_reg && addr_reg == PDC_CFR_ONE_OFFSET) begin
            cfr_one_reg <= HWDATA_I & PDC_CFR_ONE_MASK;
        end
    end

    pdc_decode u_decode (
        .ext_pd_i  (pin_sync_reg),
        .cfr_one_i (cfr_one_reg),
        .mode_o    (mode),
        .dig_pd_o  (dig_pd),
        .pll_pd_o  (pll_pd),
        .dac_pd_o  (dac_pd),
        .clk_pd_o  (clk_pd)
    );

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (bus_go && !HWRITE_I) begin
            if (HADDR_I == PDC_CFR_ONE_OFFSET) begin
                // Forward a write still in its data phase so back-to-back reads see it
                if (wr_pend_reg && addr_reg == PDC_CFR_ONE_OFFSET) begin
                    rdata_next = HWDATA_I & PDC_CFR_ONE_MASK;
                end else begin
                    rdata_next = cfr_one_reg;
                end
            end else if (HADDR_I == PDC_STATUS_OFFSET) begin
                rdata_next[PDC_ST_DIG_BIT]               = DIGITAL_PD_O;
                rdata_next[PDC_ST_PLL_BIT]               = PLL_PD_O;
                rdata_next[PDC_ST_DAC_BIT]               = DAC_PD_O;
                rdata_next[PDC_ST_CLK_BIT]               = CLOCK_IN_PD_O;
                rdata_next[PDC_ST_PIN_BIT]               = pin_sync_reg;
                rdata_next[PDC_ST_MODE_LSB+1:PDC_ST_MODE_LSB] = mode;
            end
        end
    end

    // Read data registered at the address phase; zero-wait answer
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (bus_go) begin
            HRDATA_O <= rdata_next;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
        end
    end

    // Outputs high request low power; registered for glitch-free drive
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            DIGITAL_PD_O  <= 1'b0;
            PLL_PD_O      <= 1'b0;
            DAC_PD_O      <= 1'b0;
            CLOCK_IN_PD_O <= 1'b0;
        end else begin
            DIGITAL_PD_O  <= dig_pd;
            PLL_PD_O      <= pll_pd;
            DAC_PD_O      <= dac_pd;
            CLOCK_IN_PD_O <= clk_pd;
        end
    end
endmodule // pdc_top
`default_nettype wire

// *** pdc_assertions.sv ***
// Power-down output checks
`default_nettype none
module pdc_assertions (
    input wire logic        CORE_CLK_I,
    input wire logic        RSTN_I,
    input wire logic        EXTERNAL_POWER_DOWN_PIN_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic        DIGITAL_PD_O,
    input wire logic        PLL_PD_O,
    input wire logic        DAC_PD_O,
    input wire logic        CLOCK_IN_PD_O
);
    logic       w_reg;
    logic [7:0] c_reg, q_reg;
    logic [2:0] p_reg;
    logic [1:0] n_reg;
    logic       sw, ext;
    assign sw  = n_reg == 2'h3 && !p_reg[2];
    assign ext = n_reg == 2'h3 && p_reg[2];
    always_ff @(posedge CORE_CLK_I) begin
        w_reg <= RSTN_I && HWRITE_I && HTRANS_I[1] && HADDR_I == 32'h0;
        c_reg <= !RSTN_I ? 8'h00 : w_reg ? HWDATA_I[7:0] : c_reg;
        q_reg <= c_reg;
        p_reg <= {p_reg[1:0], EXTERNAL_POWER_DOWN_PIN_I};
        // Pin history is trusted only three edges after reset
        n_reg <= !RSTN_I ? 2'h0 : n_reg + {1'b0, n_reg != 2'h3};
    end
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);
    AST_PLL: assert property (n_reg == 2'h3 |-> PLL_PD_O == q_reg[6])
        else $error("pll wrong");
    AST_SW_DIG: assert property (sw |-> DIGITAL_PD_O == q_reg[7])
        else $error("digital wrong");
    AST_SW_DAC: assert property (sw |-> DAC_PD_O == q_reg[5])
        else $error("dac wrong");
    AST_SW_CLK: assert property (sw |-> CLOCK_IN_PD_O == q_reg[4])
        else $error("clock wrong");
    AST_EXT_DIG: assert property (ext |-> DIGITAL_PD_O)
        else $error("digital up");
    AST_FAST: assert property (ext && !q_reg[3] |-> !DAC_PD_O && !CLOCK_IN_PD_O)
        else $error("fast mode wrong");
    AST_FULL: assert property (ext && q_reg[3] |-> DAC_PD_O && CLOCK_IN_PD_O)
        else $error("full mode wrong");
    cover property (ext && q_reg[3]);
    cover property (ext && !q_reg[3]);
    cover property (sw && q_reg[7]);
endmodule // pdc_assertions
`default_nettype wire

// *** test_power_down_control_decode.sv ***
// Bench for the power-down decode block
`default_nettype none
module test_power_down_control_decode;
    timeunit 1ns;
    timeprecision 1ns;
    import pdc_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, pin = 1'b0, hwr = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, v;
    logic        rdy, dig, pll, dac, ck, hresp;
    logic [8:0]  corner [4] = '{9'h0F8, 9'h100, 9'h108, 9'h1F0};
    int          failures = 0, checked = 0, cyc = 0;
    pdc_top u_pdc_top (.CORE_CLK_I(clk), .RSTN_I(rstn), .EXTERNAL_POWER_DOWN_PIN_I(pin),
        .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwr), .HSIZE_I(3'h2),
        .HWDATA_I(hwdata), .HREADY_I(rdy), .HRDATA_O(hrdata), .HREADYOUT_O(rdy), .HRESP_O(hresp),
        .DIGITAL_PD_O(dig), .PLL_PD_O(pll), .DAC_PD_O(dac), .CLOCK_IN_PD_O(ck));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            conclude();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Pin high forces digital down; bit 3 then picks the DAC and clock level
    function automatic logic [31:0] expect_pd(input logic [31:0] d);
        return {28'h0, d[8] | d[7], d[6], d[8] ? d[3] : d[5], d[8] ? d[3] : d[4]};
    endfunction
    // Status word: mode 10 full, 01 fast, 00 software; pin; clock, dac, pll, digital
    function automatic logic [31:0] expect_status(input logic [31:0] d);
        logic [31:0] e;
        e = expect_pd(d);
        return {25'h0, d[8] & d[3], d[8] & !d[3], d[8], e[0], e[1], e[2], e[3]};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= PDC_HTRANS_NONSEQ;
        haddr  <= a;
        hwr    <= w;
        do @(posedge clk); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = hrdata;
    endtask
    task automatic conclude;
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        v = 32'h1765;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        chk("reset outputs", 32'h0, {28'h0, dig, pll, dac, ck});
        for (int i = 0; i < 20; i++) begin
            v = i < 4 ? {v[31:9], corner[i]} : lfsr(v);
            xfer(1'b1, PDC_CFR_ONE_OFFSET, v);
            pin <= v[8];
            repeat (4) @(posedge clk);
            chk("outputs", expect_pd(v), {28'h0, dig, pll, dac, ck});
            xfer(1'b0, PDC_CFR_ONE_OFFSET, 32'h0);
            chk("register", v & PDC_CFR_ONE_MASK, rd);
            xfer(1'b0, PDC_STATUS_OFFSET, 32'h0);
            chk("status", expect_status(v), rd);
            chk("response", 32'h0, {31'h0, hresp});
        end
        xfer(1'b0, PDC_STATUS_OFFSET + PDC_STATUS_OFFSET + PDC_STATUS_OFFSET, 32'h0);
        chk("unmapped", 32'h0, rd);
        conclude();
    end
endmodule // test_power_down_control_decode
bind pdc_top pdc_assertions u_pdc_assertions (.CORE_CLK_I, .RSTN_I, .EXTERNAL_POWER_DOWN_PIN_I,
    .HADDR_I, .HTRANS_I, .HWRITE_I, .HWDATA_I, .DIGITAL_PD_O, .PLL_PD_O, .DAC_PD_O, .CLOCK_IN_PD_O);
`default_nettype wire
